// *** rtl/rcd_pkg.sv ***
// package of the radio command decoder: opcodes, states, field widths
// assumes one clock domain; bytes arrive already deframed from the host link
package rcd_pkg;
	localparam logic [7:0] OP_STATUS = 8'hc0;
	localparam logic [7:0] OP_REG_WR = 8'h18;
	localparam logic [7:0] OP_REG_RD = 8'h19;
	localparam logic [7:0] OP_BUF_WR = 8'h1a;
	localparam logic [7:0] OP_BUF_RD = 8'h1b;
	localparam logic [7:0] OP_SLEEP = 8'h84;
	localparam logic [7:0] OP_IDLE = 8'h80;
	localparam logic [7:0] OP_SYNTH = 8'hc1;
	localparam logic [7:0] OP_TX = 8'h83;
	localparam logic [7:0] OP_RX = 8'h82;
	localparam logic [7:0] OP_SNIFF = 8'h94;
	localparam logic [7:0] OP_DETECT = 8'hc5;
	localparam logic [7:0] OP_CW = 8'hd1;
	localparam logic [7:0] OP_PREAMBLE = 8'hd2;
	localparam logic [7:0] OP_SAVE_CTX = 8'hd5;
	localparam logic [7:0] OP_FTYPE_SET = 8'h8a;
	localparam logic [7:0] OP_FTYPE_GET = 8'h03;
	localparam logic [7:0] OP_FREQ = 8'h86;
	localparam logic [7:0] OP_TX_POWER = 8'h8e;
	localparam logic [7:0] OP_DETECT_CFG = 8'h88;
	localparam logic [7:0] OP_BUF_BASE = 8'h8f;
	localparam logic [7:0] OP_MOD_CFG = 8'h8b;
	localparam logic [7:0] OP_FRAME_FMT = 8'h8c;
	localparam logic [7:0] OP_IRQ_ROUTE = 8'h8d;
	localparam logic [7:0] OP_IRQ_READ = 8'h15;
	localparam logic [7:0] OP_IRQ_CLEAR = 8'h97;
	localparam logic [7:0] OP_SYNTH_HOLD = 8'h9e;
	localparam logic [7:0] OP_AUTO_TX = 8'h98;
	localparam logic [7:0] OP_RANGE_ROLE = 8'ha3;
	localparam logic [7:0] OP_EXT_RANGE = 8'h9a;
	// parameter byte counts; len_unknown marks an opcode outside the set
	localparam logic [3:0] LEN_UNKNOWN = 4'hf;
	localparam logic [3:0] LEN_NONE = 4'h0;
	localparam logic [3:0] LEN_OFFSET = 4'h1;
	localparam logic [3:0] LEN_ADDR = 4'h2;
	localparam logic [3:0] LEN_TIMEOUT = 4'h3;
	localparam logic [3:0] LEN_SNIFF = 4'h6;
	localparam logic [3:0] LEN_FRAME = 4'h7;
	localparam logic [3:0] LEN_ROUTE = 4'h8;
	localparam int IRQ_W = 16;
	localparam int PINS = 3;
	typedef enum logic [1:0] {
		RCD_WAIT_OP = 2'b00,
		RCD_PARAMS = 2'b01,
		RCD_STREAM = 2'b11,
		RCD_DISCARD = 2'b10
	} rcd_state_t;
endpackage

// *** rtl/rcd_decoder.sv ***
// host command decoder: opcode byte, parameter bytes, response bytes, irq flags
// assumes bytes come from a deframer, a start pulse opens each transaction,
// and register/buffer stores answer reads combinationally in the same cycle
// How it works
// - opcode byte leads each transaction; 0xc0 returns the status byte
// - 0x18: address high then low, data bytes stored at consecutive addresses
// - 0x19: address high then low, bytes returned from consecutive addresses
// - 0x1a writes, 0x1b reads payload buffer from a one-byte offset
// - 0x84 carries sleep config, 0x80 idle config; no reply data
// - 0x83 carries step byte then 16-bit step count, high byte first
// - 0x82 carries the same step layout as transmit
// - 0x94 carries receive step, count, sleep step, count: six bytes
// - 0x86 carries a 24-bit carrier word, top byte first
// - 0x8e carries output power then power ramp
// - 0x8f carries transmit base then receive base offsets
// - 0x8c carries seven frame format bytes in order
// - 0x8d carries enable mask then three pin route masks, high byte first
// - 0x15 returns the 16-bit flag register, high byte first
// - 0x97 carries a 16-bit clear mask, high byte first
// - 0x9e: zero disables, one enables synthesizer hold
// - 0xa3: zero responder, one initiator role
// - 0x9a: zero disables, one enables extended ranging
// - 0xc5 has no parameters; 0x88 sets symbol count byte
// - 0x98 carries a time parameter for automatic transmit
// - flag register logs sources, each only while its enable bit is one
// - clear command drops flags with mask one unless their enabled source fires in that cycle, keeps the others
// - each pin is the or of enabled flags routed to it
module rcd_decoder
	import rcd_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// host byte stream
	input wire logic cmd_start,
	input wire logic byte_valid,
	input wire logic [7:0] byte_in,
	output logic [7:0] reply_byte,
	input wire logic [7:0] status_byte,
	// register store
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// payload buffer
	output logic buf_wr,
	output logic buf_rd,
	output logic [7:0] buf_addr,
	output logic [7:0] buf_wdata,
	input wire logic [7:0] buf_rdata,
	// executed command notice
	output logic cmd_done,
	output logic [7:0] cmd_code,
	// configuration
	output logic [7:0] sleep_cfg,
	output logic [7:0] idle_cfg,
	output logic [7:0] timeout_step,
	output logic [15:0] timeout_steps,
	output logic [47:0] sniff_cfg,
	output logic [7:0] frame_type,
	output logic [23:0] carrier_freq,
	output logic [7:0] tx_power,
	output logic [7:0] power_ramp,
	output logic [7:0] tx_base,
	output logic [7:0] rx_base,
	output logic [23:0] modulation_cfg,
	output logic [55:0] frame_format,
	output logic [7:0] detect_symbol_count,
	output logic [15:0] auto_tx_time,
	output logic synth_hold,
	output logic range_initiator,
	output logic extended_range,
	// interrupts
	input wire logic [IRQ_W-1:0] irq_src,
	output logic [IRQ_W-1:0] irq_enable_mask,
	output logic [IRQ_W-1:0] irq_flags,
	output logic [PINS-1:0] irq_pins
);
	typedef struct packed {
		rcd_state_t st;
		logic [7:0] op;
		logic [3:0] cnt;
		logic [63:0] pbuf;
		logic [15:0] addr;
		logic fetch;
		logic wr;
		logic [7:0] wdata;
		logic [7:0] reply;
		logic done;
		logic [7:0] code;
		logic [7:0] sleep_c, idle_c, step, ftype, pwr, ramp, txb, rxb, sym;
		logic [15:0] steps, auto_t;
		logic [47:0] sniff;
		logic [23:0] freq, modc;
		logic [55:0] ffmt;
		logic hold, role, ext;
		logic [IRQ_W-1:0] en, flags;
		logic [PINS*IRQ_W-1:0] route;
		logic [PINS-1:0] pins;
	} rcd_regs_t;

	rcd_regs_t s_reg, s_next;

	// parameter bytes after each opcode; shared by decode and checks
	function automatic logic [3:0] param_len(input logic [7:0] op);
		case (op)
			OP_STATUS, OP_SYNTH, OP_DETECT, OP_CW, OP_PREAMBLE, OP_SAVE_CTX,
			OP_FTYPE_GET, OP_IRQ_READ: param_len = LEN_NONE;
			OP_BUF_WR, OP_BUF_RD, OP_SLEEP, OP_IDLE, OP_FTYPE_SET, OP_DETECT_CFG,
			OP_SYNTH_HOLD, OP_RANGE_ROLE, OP_EXT_RANGE: param_len = LEN_OFFSET;
			OP_REG_WR, OP_REG_RD, OP_TX_POWER, OP_BUF_BASE, OP_IRQ_CLEAR,
			OP_AUTO_TX: param_len = LEN_ADDR;
			OP_TX, OP_RX, OP_FREQ, OP_MOD_CFG: param_len = LEN_TIMEOUT;
			OP_SNIFF: param_len = LEN_SNIFF;
			OP_FRAME_FMT: param_len = LEN_FRAME;
			OP_IRQ_ROUTE: param_len = LEN_ROUTE;
			default: param_len = LEN_UNKNOWN;
		endcase
	endfunction

	logic fire;
	logic [7:0] cop;
	logic [63:0] p;
	logic [IRQ_W-1:0] clr;
	rcd_state_t cur;

	// decode, parameter capture, commit and flag update
	always_comb
	begin
		s_next = s_reg;
		fire = 1'b0;
		cop = s_reg.op;
		clr = '0;
		p = {s_reg.pbuf[55:0], byte_in};
		cur = cmd_start ? RCD_WAIT_OP : s_reg.st;
		s_next.done = 1'b0;
		s_next.fetch = 1'b0;
		s_next.wr = 1'b0;
		if (cmd_start)
		begin
			s_next.st = RCD_WAIT_OP;
			s_next.reply = 8'h00;
		end
		// address advances after each store access
		if (s_reg.wr || s_reg.fetch)
			s_next.addr = s_reg.addr + 16'h0001;
		if (s_reg.fetch)
			s_next.reply = (s_reg.op == OP_REG_RD) ? reg_rdata : buf_rdata;
		if (byte_valid)
		begin
			case (cur)
				RCD_WAIT_OP:
				begin
					cop = byte_in;
					s_next.op = byte_in;
					s_next.cnt = param_len(byte_in);
					if (param_len(byte_in) == LEN_UNKNOWN)
						s_next.st = RCD_DISCARD;
					else if (param_len(byte_in) == LEN_NONE)
						fire = 1'b1;
					else
						s_next.st = RCD_PARAMS;
				end
				RCD_PARAMS:
				begin
					s_next.pbuf = p;
					s_next.cnt = s_reg.cnt - 4'h1;
					if (s_reg.cnt == LEN_OFFSET)
						fire = 1'b1;
				end
				RCD_STREAM:
				begin
					s_next.cnt = s_reg.cnt + 4'h1;
					if (s_reg.op == OP_REG_WR || s_reg.op == OP_BUF_WR)
					begin
						s_next.wr = 1'b1;
						s_next.wdata = byte_in;
					end
					else if (s_reg.op == OP_REG_RD || s_reg.op == OP_BUF_RD)
						s_next.fetch = 1'b1;
					else if (s_reg.op == OP_IRQ_READ && s_reg.cnt == LEN_NONE)
						s_next.reply = s_reg.addr[7:0];
					else
						s_next.reply = 8'h00;
				end
				RCD_DISCARD: s_next.st = RCD_DISCARD;
				default: s_next.st = RCD_WAIT_OP;
			endcase
		end
		// commit once the last parameter byte is in
		if (fire)
		begin
			s_next.done = 1'b1;
			s_next.code = cop;
			s_next.st = RCD_STREAM; // stray trailing bytes must not decode as opcodes
			case (cop)
				OP_STATUS:
				begin
					s_next.reply = status_byte;
					s_next.st = RCD_STREAM;
				end
				OP_FTYPE_GET:
				begin
					s_next.reply = s_reg.ftype;
					s_next.st = RCD_STREAM;
				end
				OP_IRQ_READ:
				begin
					s_next.reply = s_reg.flags[15:8];
					s_next.addr = s_reg.flags;
					s_next.cnt = LEN_NONE;
					s_next.st = RCD_STREAM;
				end
				OP_REG_WR, OP_REG_RD:
				begin
					s_next.addr = p[15:0];
					s_next.fetch = (cop == OP_REG_RD);
					s_next.st = RCD_STREAM;
				end
				OP_BUF_WR, OP_BUF_RD:
				begin
					s_next.addr = {8'h00, p[7:0]};
					s_next.fetch = (cop == OP_BUF_RD);
					s_next.st = RCD_STREAM;
				end
				OP_SLEEP: s_next.sleep_c = p[7:0];
				OP_IDLE: s_next.idle_c = p[7:0];
				OP_TX, OP_RX:
				begin
					s_next.step = p[23:16];
					s_next.steps = p[15:0];
				end
				OP_SNIFF: s_next.sniff = p[47:0];
				OP_FTYPE_SET: s_next.ftype = p[7:0];
				OP_FREQ: s_next.freq = p[23:0];
				OP_TX_POWER:
				begin
					s_next.pwr = p[15:8];
					s_next.ramp = p[7:0];
				end
				OP_BUF_BASE:
				begin
					s_next.txb = p[15:8];
					s_next.rxb = p[7:0];
				end
				OP_MOD_CFG: s_next.modc = p[23:0];
				OP_FRAME_FMT: s_next.ffmt = p[55:0];
				OP_IRQ_ROUTE:
				begin
					s_next.en = p[63:48];
					s_next.route = p[47:0];
				end
				OP_IRQ_CLEAR: clr = p[15:0];
				OP_DETECT_CFG: s_next.sym = p[7:0];
				OP_AUTO_TX: s_next.auto_t = p[15:0];
				OP_SYNTH_HOLD: s_next.hold = p[0];
				OP_RANGE_ROLE: s_next.role = p[0];
				OP_EXT_RANGE: s_next.ext = p[0];
				default: s_next.st = RCD_STREAM;
			endcase
		end
		// a source event in the clearing cycle survives: set beats clear
		s_next.flags = (s_reg.flags & ~clr) | (irq_src & s_reg.en);
		for (int i = 0; i < PINS; i++)
			s_next.pins[i] = |(s_reg.flags & s_reg.en & s_reg.route[(PINS-1-i)*IRQ_W +: IRQ_W]);
	end

	// one register bank for all state
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// store strobes are combinational from registered state
	assign reg_wr = s_reg.wr && s_reg.op == OP_REG_WR;
	assign reg_rd = s_reg.fetch && s_reg.op == OP_REG_RD;
	assign buf_wr = s_reg.wr && s_reg.op == OP_BUF_WR;
	assign buf_rd = s_reg.fetch && s_reg.op == OP_BUF_RD;
	assign reg_addr = s_reg.addr;
	assign buf_addr = s_reg.addr[7:0];
	assign reg_wdata = s_reg.wdata;
	assign buf_wdata = s_reg.wdata;
	assign reply_byte = s_reg.reply;
	assign cmd_done = s_reg.done;
	assign cmd_code = s_reg.code;
	assign sleep_cfg = s_reg.sleep_c;
	assign idle_cfg = s_reg.idle_c;
	assign timeout_step = s_reg.step;
	assign timeout_steps = s_reg.steps;
	assign sniff_cfg = s_reg.sniff;
	assign frame_type = s_reg.ftype;
	assign carrier_freq = s_reg.freq;
	assign tx_power = s_reg.pwr;
	assign power_ramp = s_reg.ramp;
	assign tx_base = s_reg.txb;
	assign rx_base = s_reg.rxb;
	assign modulation_cfg = s_reg.modc;
	assign frame_format = s_reg.ffmt;
	assign detect_symbol_count = s_reg.sym;
	assign auto_tx_time = s_reg.auto_t;
	assign synth_hold = s_reg.hold;
	assign range_initiator = s_reg.role;
	assign extended_range = s_reg.ext;
	assign irq_enable_mask = s_reg.en;
	assign irq_flags = s_reg.flags;
	assign irq_pins = s_reg.pins;

	// checks
	a_status_reply: assert property (@(posedge clock) disable iff (reset)
		(cmd_start && byte_valid && byte_in == OP_STATUS) |=> reply_byte == $past(status_byte))
		else $error("status byte not returned");
	a_reg_write: assert property (@(posedge clock) disable iff (reset)
		(s_reg.st == RCD_STREAM && s_reg.op == OP_REG_WR && byte_valid && !cmd_start)
		|=> reg_wr && reg_wdata == $past(byte_in) ##1 reg_addr == $past(reg_addr, 1) + 16'h0001)
		else $error("register write not stored or address not advanced");
	a_read_capture: assert property (@(posedge clock) disable iff (reset)
		reg_rd |=> reply_byte == $past(reg_rdata))
		else $error("register read data not returned");
	a_frame_get: assert property (@(posedge clock) disable iff (reset)
		(cmd_start && byte_valid && byte_in == OP_FTYPE_GET) |=> reply_byte == $past(frame_type))
		else $error("frame type not returned");
	a_flag_gate: assert property (@(posedge clock) disable iff (reset)
		1'b1 |=> (irq_flags & ~$past(irq_flags) & ~$past(irq_src & irq_enable_mask)) == '0)
		else $error("flag set without enabled source");
	a_flag_logs: assert property (@(posedge clock) disable iff (reset)
		1'b1 |=> (irq_flags & $past(irq_src & irq_enable_mask)) == $past(irq_src & irq_enable_mask))
		else $error("enabled source not logged");
	a_clear_only: assert property (@(posedge clock) disable iff (reset)
		1'b1 |=> ($past(irq_flags) & ~irq_flags & ~$past(clr)) == '0)
		else $error("flag dropped without clear");
	a_pin_or: assert property (@(posedge clock) disable iff (reset)
		(irq_flags & irq_enable_mask) == '0 |=> irq_pins == '0)
		else $error("pin high with no enabled flag");
	a_unknown_ignore: assert property (@(posedge clock) disable iff (reset)
		(cmd_start && byte_valid && param_len(byte_in) == LEN_UNKNOWN)
		|=> !cmd_done && $stable(frame_type) && $stable(irq_enable_mask) && s_reg.st == RCD_DISCARD)
		else $error("unknown opcode changed state");
endmodule

// *** sim/rcd_store_model.sv ***
// register file and payload buffer behind the command decoder
// assumes reads are answered combinationally in the strobe cycle
module rcd_store_model (
	// clock
	input wire logic clock,
	// register side
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// payload buffer side
	input wire logic buf_wr,
	input wire logic buf_rd,
	input wire logic [7:0] buf_addr,
	input wire logic [7:0] buf_wdata,
	output logic [7:0] buf_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] regs [65536];
	logic [7:0] pay [256];
	logic [7:0] junk = 8'h5a;
	// writes land at the strobe edge; junk churns every cycle
	always @(posedge clock)
	begin
		junk <= ~junk + 8'h01;
		if (reg_wr)
			regs[reg_addr] <= reg_wdata;
		if (buf_wr)
			pay[buf_addr] <= buf_wdata;
	end
	// off-read lines churn so a late sample never sees stale data
	assign reg_rdata = reg_rd ? regs[reg_addr] : junk;
	assign buf_rdata = buf_rd ? pay[buf_addr] : ~junk;
endmodule

// *** sim/tb_radio_command_decoder.sv ***
// bench of the radio command decoder: host byte driver and result watcher
// assumes the store model answers reads in the strobe cycle
module tb_radio_command_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	import rcd_pkg::*;
	typedef struct {logic [7:0] op; logic [63:0] val;} rcd_note_t;
	logic clock, reset, cmd_start, byte_valid, reg_wr, reg_rd, buf_wr, buf_rd, cmd_done;
	logic synth_hold, range_initiator, extended_range, reply_due, pend;
	logic [7:0] byte_in, reply_byte, status_byte, reg_wdata, reg_rdata, buf_addr, buf_wdata, buf_rdata;
	logic [7:0] cmd_code, sleep_cfg, idle_cfg, timeout_step, frame_type, tx_power, power_ramp;
	logic [7:0] tx_base, rx_base, detect_symbol_count, last_ft;
	logic [15:0] reg_addr, timeout_steps, auto_tx_time;
	logic [23:0] carrier_freq, modulation_cfg;
	logic [47:0] sniff_cfg;
	logic [55:0] frame_format;
	logic [IRQ_W-1:0] irq_src, irq_enable_mask, irq_flags;
	logic [PINS-1:0] irq_pins;
	logic [31:0] seed;
	int n_errors, num_checks;
	rcd_note_t dq[$];
	rcd_note_t cur;
	logic [7:0] rq[$];
	localparam logic [7:0] CFG_OPS [17] = '{OP_SLEEP, OP_IDLE, OP_TX, OP_RX, OP_SNIFF, OP_FTYPE_SET, OP_FREQ,
		OP_TX_POWER, OP_BUF_BASE, OP_MOD_CFG, OP_FRAME_FMT, OP_DETECT_CFG, OP_AUTO_TX, OP_IRQ_ROUTE,
		OP_SYNTH_HOLD, OP_RANGE_ROLE, OP_EXT_RANGE};
	localparam int CFG_LEN [17] = '{1, 1, 3, 3, 6, 1, 3, 2, 2, 3, 7, 1, 2, 8, 1, 1, 1};
	localparam logic [7:0] NOPAR [5] = '{OP_DETECT, OP_SYNTH, OP_CW, OP_PREAMBLE, OP_SAVE_CTX};
	localparam logic [7:0] BAD_OPS [6] = '{8'h96, 8'h9b, 8'h9d, 8'h17, 8'h1d, 8'h1f};
	localparam logic [15:0] CLR [3] = '{16'h0001, 16'h4000, 16'hffff};
	localparam logic [15:0] LEFT [3] = '{16'h4022, 16'h0022, 16'h0000};
	localparam logic [2:0] PIN_EXP [3] = '{3'b110, 3'b110, 3'b000};

	rcd_decoder rcd_decoder_i (.clock, .reset, .cmd_start, .byte_valid, .byte_in, .reply_byte, .status_byte,
		.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .buf_wr, .buf_rd, .buf_addr, .buf_wdata,
		.buf_rdata, .cmd_done, .cmd_code, .sleep_cfg, .idle_cfg, .timeout_step, .timeout_steps, .sniff_cfg,
		.frame_type, .carrier_freq, .tx_power, .power_ramp, .tx_base, .rx_base, .modulation_cfg,
		.frame_format, .detect_symbol_count, .auto_tx_time, .synth_hold, .range_initiator, .extended_range,
		.irq_src, .irq_enable_mask, .irq_flags, .irq_pins);
	rcd_store_model rcd_store_model_i (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.buf_wr, .buf_rd, .buf_addr, .buf_wdata, .buf_rdata);

	// bench clock, 40 ns period
	always #20 clock = ~clock;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// observed configuration word for an opcode; zero for commands without one
	function automatic logic [63:0] cfg_of(input logic [7:0] op);
		case (op)
			OP_SLEEP: return 64'(sleep_cfg);
			OP_IDLE: return 64'(idle_cfg);
			OP_TX, OP_RX: return 64'({timeout_step, timeout_steps});
			OP_SNIFF: return 64'(sniff_cfg);
			OP_FTYPE_SET: return 64'(frame_type);
			OP_FREQ: return 64'(carrier_freq);
			OP_TX_POWER: return 64'({tx_power, power_ramp});
			OP_BUF_BASE: return 64'({tx_base, rx_base});
			OP_MOD_CFG: return 64'(modulation_cfg);
			OP_FRAME_FMT: return 64'(frame_format);
			OP_DETECT_CFG: return 64'(detect_symbol_count);
			OP_AUTO_TX: return 64'(auto_tx_time);
			OP_SYNTH_HOLD: return 64'(synth_hold);
			OP_RANGE_ROLE: return 64'(range_initiator);
			OP_EXT_RANGE: return 64'(extended_range);
			OP_IRQ_ROUTE: return 64'(irq_enable_mask);
			default: return 64'h0;
		endcase
	endfunction

	task automatic chk64(input string what, input logic [63:0] exp, input logic [63:0] seen);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] seen);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	// one host byte, then a spacing that also covers read latency
	task automatic send(input logic [7:0] b, input logic st);
		@(posedge clock);
		cmd_start <= st;
		byte_valid <= 1'b1;
		byte_in <= b;
		@(posedge clock);
		cmd_start <= 1'b0;
		byte_valid <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	task automatic expect_reply(input logic [7:0] b);
		rq.push_back(b);
		reply_due <= 1'b1;
		@(posedge clock);
		reply_due <= 1'b0;
	endtask

	// opcode plus n bytes, random or taken top byte first from pv
	task automatic cmd(input logic [7:0] op, input int n, input logic [63:0] pv, input bit rnd);
		logic [63:0] v;
		logic [7:0] p [8];
		v = '0;
		for (int i = 0; i < n; i++)
		begin
			seed = lfsr(seed);
			p[i] = rnd ? seed[7:0] : pv[8*(n-1-i)+:8];
			v = {v[55:0], p[i]};
		end
		if (op == OP_FTYPE_SET)
			last_ft = v[7:0];
		// the clear mask leaves no standing output; its effect shows in the flag reads
		dq.push_back('{op, (op == OP_IRQ_ROUTE) ? v >> 48 : (op == OP_IRQ_CLEAR) ? 64'h0 : v});
		send(op, 1'b1);
		for (int i = 0; i < n; i++)
			send(p[i], 1'b0);
	endtask

	// write three bytes across a low-byte boundary, read them back
	task automatic mem_test(input logic [7:0] wop, input logic [7:0] rop, input logic [15:0] a, input int na);
		logic [7:0] d [3];
		dq.push_back('{wop, 64'h0});
		send(wop, 1'b1);
		if (na == 2)
			send(a[15:8], 1'b0);
		send(a[7:0], 1'b0);
		for (int i = 0; i < 3; i++)
		begin
			seed = lfsr(seed);
			d[i] = seed[7:0];
			send(d[i], 1'b0);
		end
		dq.push_back('{rop, 64'h0});
		send(rop, 1'b1);
		if (na == 2)
			send(a[15:8], 1'b0);
		send(a[7:0], 1'b0);
		for (int i = 0; i < 3; i++)
		begin
			if (i > 0)
				send(8'h00, 1'b0);
			expect_reply(d[i]);
		end
	endtask

	task automatic irq_check(input logic [15:0] f, input logic [2:0] pins);
		@(negedge clock);
		chk8("interrupt pins", {5'h0, pins}, {5'h0, irq_pins});
		cmd(OP_IRQ_READ, 0, 64'h0, 1'b0);
		expect_reply(f[15:8]);
		send(8'h00, 1'b0);
		expect_reply(f[7:0]);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// watcher: done notices against the oldest note, reply bytes against the oldest expected reply
	always @(posedge clock)
	begin
		if (pend)
		begin
			chk64("command code", 64'(cur.op), 64'(cmd_code));
			chk64("configuration", cur.val, cfg_of(cur.op));
		end
		pend = 1'b0;
		if (cmd_done === 1'b1 && dq.size() == 0)
		begin
			n_errors++;
			$display("unexpected command done: expected none seen %h", cmd_code);
		end
		else if (cmd_done === 1'b1)
		begin
			cur = dq.pop_front();
			pend = 1'b1;
		end
		if (reply_due === 1'b1)
			chk8("reply byte", rq.pop_front(), reply_byte);
	end

	// hang guard: bounded, ends in the closing report
	initial
	begin
		repeat (20000) @(posedge clock);
		n_errors++;
		$display("unexpected timeout: expected end seen hang");
		stop_test();
	end

	initial
	begin
		clock = 1'b0;
		reset = 1'b1;
		cmd_start = 1'b0;
		byte_valid = 1'b0;
		byte_in = 8'h00;
		status_byte = 8'h00;
		irq_src = '0;
		reply_due = 1'b0;
		pend = 1'b0;
		seed = 32'h5e0f8da2;
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		// single-bit commands get zero on the first pass, one on the second
		for (int r = 0; r < 2; r++)
			for (int k = 0; k < 17; k++)
				cmd(CFG_OPS[k], CFG_LEN[k], 64'(r), k < 14);
		foreach (NOPAR[i])
			cmd(NOPAR[i], 0, 64'h0, 1'b0);
		// a trailing byte without start must not act as an opcode: no done notice
		send(OP_SYNTH, 1'b0);
		$display("test configuration commands done");
		seed = lfsr(seed);
		status_byte <= seed[7:0];
		cmd(OP_STATUS, 0, 64'h0, 1'b0);
		expect_reply(seed[7:0]);
		cmd(OP_FTYPE_GET, 0, 64'h0, 1'b0);
		expect_reply(last_ft);
		// unknown opcode followed by bytes that look like a frame type set
		foreach (BAD_OPS[i])
		begin
			send(BAD_OPS[i], 1'b1);
			send(OP_FTYPE_SET, 1'b0);
			send(~last_ft, 1'b0);
		end
		cmd(OP_FTYPE_GET, 0, 64'h0, 1'b0);
		expect_reply(last_ft);
		$display("test queries and unknown opcodes done");
		seed = lfsr(seed);
		mem_test(OP_REG_WR, OP_REG_RD, {seed[15:8], 8'hfe}, 2);
		mem_test(OP_BUF_WR, OP_BUF_RD, 16'h00fe, 1);
		$display("test register and buffer access done");
		cmd(OP_IRQ_ROUTE, 8, 64'h4023_0001_0002_4020, 1'b0);
		irq_src <= '1;
		@(posedge clock);
		irq_src <= '0;
		repeat (3) @(posedge clock);
		irq_check(16'h4023, 3'b111);
		for (int i = 0; i < 3; i++)
		begin
			cmd(OP_IRQ_CLEAR, 2, 64'(CLR[i]), 1'b0);
			irq_check(LEFT[i], PIN_EXP[i]);
		end
		$display("test interrupt flags done");
		repeat (4) @(posedge clock);
		chk64("pending notes", 64'h0, 64'(dq.size()));
		stop_test();
	end
endmodule
